// [src/mcs_led_map.vh]
`ifndef MCS_LED_MAP_VH
`define MCS_LED_MAP_VH

// Register offsets (byte addresses, one word each)
`define MCS_OFF_CTRL     4'h0
`define MCS_OFF_STATUS   4'h4
`define MCS_OFF_IRQSTAT  4'h8
`define MCS_OFF_IRQMASK  4'hC

// Control register fields
`define MCS_CTRL_DRVSTART   0
`define MCS_CTRL_PROGLOAD   1
`define MCS_CTRL_RESET      32'h0000_0000

// Interrupt status fields
`define MCS_IRQ_FAULT    0
`define MCS_IRQ_RING     1
`define MCS_IRQ_PHASE    2
`define MCS_IRQ_WIDTH    3
`define MCS_IRQ_RESET    3'h0

// Status register fields
`define MCS_ST_DUAL_LSB  0
`define MCS_ST_HLTH_LSB  2
`define MCS_ST_RING_LSB  4
`define MCS_ST_PHS_LSB   6
`define MCS_ST_PHASE_LSB 8

// Colour codes on a bi-colour pair {red, green}
`define MCS_LED_OFF      2'h0
`define MCS_LED_GREEN    2'h1
`define MCS_LED_RED      2'h2
`define MCS_LED_ORANGE   2'h3

// Blink timebase: half period in ms, clock in kHz
`define MCS_BLINK_HALF_MS 500
`define MCS_CLK_KHZ       100000
`define MCS_BLINK_HALF_CYC (`MCS_BLINK_HALF_MS * `MCS_CLK_KHZ)

`endif

// [src/mcs_blink.v]
`timescale 1ns/1ps
`include "mcs_led_map.vh"

module mcs_blink #(
  parameter HALF_CYC = `MCS_BLINK_HALF_CYC
) (
  input  wire sys_clk,
  input  wire rst_n,
  output reg  blinkPhase
);

  reg  [31:0] count;

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count      <= 32'h0000_0000;
      blinkPhase <= 1'b0;
    end
    else if (count >= HALF_CYC - 1)
    begin
      count      <= 32'h0000_0000;
      blinkPhase <= ~blinkPhase;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule

// [src/mcs_status_leds.v]
// Overview of operation
// - Two-axis LED is green at power-up, red once the driver starts, green on program load.
// - In operation the two-axis LED is green when healthy and red while a fault is present.
// - Health LED is solid red through self-test, then flashes green only if all tests pass.
// - Health LED is dark whenever the card is not operating.
// - Health LED flashes green when diagnostics passed but no communication exists yet.
// - Health LED is solid green while data is exchanged in the normal state.
// - Health LED flashes red on a major recoverable failure or during a store update.
// - Health LED is solid red on a potentially nonrecoverable fault.
// - Ring LED is solid green when ring, drives and axes are configured and communicating.
// - Ring LED flashes red on a ring setup or configuration fault.
// - Ring LED is solid red on a ring hardware or installation fault.
// - Ring LED is dark, absent a ring fault, with no ring data received or before phase 2 completes.
// - Ring LED flashes green when not configured but at least one node is identified.
// - Phase LED is orange in phase -1, dark in phase 0, flashing red in phase 1.
// - Phase LED alternates red and green in phase 2, flashes green in 3, solid green in 4.
`timescale 1ns/1ps
`include "mcs_led_map.vh"

module mcs_status_leds #(
  parameter BLINK_HALF_CYC = `MCS_BLINK_HALF_CYC
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output reg         avsWaitRequest,
  output reg         irq,
  // Internal conditions (card logic, same clock)
  input  wire        cardOperating,
  input  wire        selfTestDone,
  input  wire        selfTestPass,
  input  wire        dataExchange,
  input  wire        faultPresent,
  input  wire        majorRecoverable,
  input  wire        nonrecoverable,
  input  wire        nonvolatile_store_update,
  input  wire        ringDataSeen,
  input  wire        ringConfigured,
  input  wire        ringIdentified,
  input  wire        ringSetupFault,
  input  wire        ringHwFault,
  input  wire [2:0]  ringPhase,
  // LED drive, {red, green}
  output reg  [1:0]  dualAxisLed,
  output reg  [1:0]  healthLed,
  output reg  [1:0]  ringLed,
  output reg  [1:0]  comm_phase_indicator
);

  // Phase codes: two's complement, -1 is 3'h7
  localparam [2:0] PH_AUTOBAUD = 3'h7;
  localparam [2:0] PH_CLOSED   = 3'h0;
  localparam [2:0] PH_SEARCH   = 3'h1;
  localparam [2:0] PH_CONFIG   = 3'h2;
  localparam [2:0] PH_PARAM    = 3'h3;
  localparam [2:0] PH_ACTIVE   = 3'h4;

  // Two-axis start-up sequence states
  localparam [1:0] DS_POWERUP = 2'h0;
  localparam [1:0] DS_DRIVER  = 2'h1;
  localparam [1:0] DS_RUN     = 2'h2;

  // Health LED start-up states
  localparam [1:0] HS_TEST    = 2'h0;
  localparam [1:0] HS_PASSED  = 2'h1;
  localparam [1:0] HS_FAILED  = 2'h2;

  wire        blinkPhase;
  reg  [1:0]  dualState;
  reg  [1:0]  healthState;
  reg  [31:0] ctrl;
  reg  [2:0]  irqStat;
  reg  [2:0]  irqMask;
  reg  [1:0]  next_dualLed;
  reg  [1:0]  next_healthLed;
  reg  [1:0]  next_ringLed;
  reg  [1:0]  next_phaseLed;
  reg         faultSeen;
  reg         ringFaultPrev;
  reg  [2:0]  phasePrev;
  reg         busy;
  wire        access;
  wire        wrEvent;
  wire        fire;
  wire [2:0]  events;
  wire [31:0] statusWord;

  // Shared timebase so every flashing LED blinks in step
  mcs_blink #(
    .HALF_CYC   (BLINK_HALF_CYC)
  ) u_blink (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .blinkPhase (blinkPhase)
  );

  // Two-axis start-up sequence driven by software control bits
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      dualState <= DS_POWERUP;
    else
    begin
      case (dualState)
        DS_POWERUP:
          if (ctrl[`MCS_CTRL_DRVSTART])
            dualState <= DS_DRIVER;
        DS_DRIVER:
          if (ctrl[`MCS_CTRL_PROGLOAD])
            dualState <= DS_RUN;
        DS_RUN:
          dualState <= DS_RUN;
        default:
          dualState <= DS_POWERUP;
      endcase
    end
  end

  // Two-axis colour
  always @*
  begin
    case (dualState)
      DS_POWERUP: next_dualLed = `MCS_LED_GREEN;
      DS_DRIVER:  next_dualLed = `MCS_LED_RED;
      DS_RUN:     next_dualLed = faultPresent ? `MCS_LED_RED : `MCS_LED_GREEN;
      default:    next_dualLed = `MCS_LED_RED;
    endcase
  end

  // Self-test tracking; a failed test keeps the LED solid red
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      healthState <= HS_TEST;
    else if (!cardOperating)
      healthState <= HS_TEST;
    else
    begin
      case (healthState)
        HS_TEST:
          if (selfTestDone)
            healthState <= selfTestPass ? HS_PASSED : HS_FAILED;
        HS_PASSED:
          healthState <= HS_PASSED;
        HS_FAILED:
          healthState <= HS_FAILED;
        default:
          healthState <= HS_TEST;
      endcase
    end
  end

  // Health colour, most severe condition first
  always @*
  begin
    if (!cardOperating)
      next_healthLed = `MCS_LED_OFF;
    else if (healthState != HS_PASSED)
      next_healthLed = `MCS_LED_RED;
    else if (nonrecoverable)
      next_healthLed = `MCS_LED_RED;
    else if (majorRecoverable || nonvolatile_store_update)
      next_healthLed = blinkPhase ? `MCS_LED_RED : `MCS_LED_OFF;
    else if (dataExchange)
      next_healthLed = `MCS_LED_GREEN;
    else
      next_healthLed = blinkPhase ? `MCS_LED_GREEN : `MCS_LED_OFF;
  end

  // Ring colour; faults outrank the dark state so wiring errors show
  always @*
  begin
    if (ringHwFault)
      next_ringLed = `MCS_LED_RED;
    else if (ringSetupFault)
      next_ringLed = blinkPhase ? `MCS_LED_RED : `MCS_LED_OFF;
    // no data, or phase -1 through phase 2
    else if (!ringDataSeen || ringPhase == PH_AUTOBAUD || ringPhase <= PH_CONFIG)
      next_ringLed = `MCS_LED_OFF;
    else if (ringConfigured)
      next_ringLed = `MCS_LED_GREEN;
    else if (ringIdentified)
      next_ringLed = blinkPhase ? `MCS_LED_GREEN : `MCS_LED_OFF;
    else
      next_ringLed = `MCS_LED_OFF;
  end

  // Phase colour
  always @*
  begin
    case (ringPhase)
      PH_AUTOBAUD: next_phaseLed = `MCS_LED_ORANGE;
      PH_CLOSED:   next_phaseLed = `MCS_LED_OFF;
      PH_SEARCH:   next_phaseLed = blinkPhase ? `MCS_LED_RED : `MCS_LED_OFF;
      PH_CONFIG:   next_phaseLed = blinkPhase ? `MCS_LED_RED : `MCS_LED_GREEN;
      PH_PARAM:    next_phaseLed = blinkPhase ? `MCS_LED_GREEN : `MCS_LED_OFF;
      PH_ACTIVE:   next_phaseLed = `MCS_LED_GREEN;
      default:     next_phaseLed = `MCS_LED_OFF;
    endcase
  end

  // Registered LED outputs
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dualAxisLed          <= `MCS_LED_OFF;
      healthLed            <= `MCS_LED_OFF;
      ringLed              <= `MCS_LED_OFF;
      comm_phase_indicator <= `MCS_LED_OFF;
    end
    else
    begin
      dualAxisLed          <= next_dualLed;
      healthLed            <= next_healthLed;
      ringLed              <= next_ringLed;
      comm_phase_indicator <= next_phaseLed;
    end
  end

  // Event history; ring entry follows the fault level, not the blinking LED
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faultSeen     <= 1'b0;
      ringFaultPrev <= 1'b0;
      phasePrev     <= PH_AUTOBAUD;
    end
    else
    begin
      faultSeen     <= faultPresent | nonrecoverable | majorRecoverable;
      ringFaultPrev <= ringHwFault | ringSetupFault;
      phasePrev     <= ringPhase;
    end
  end

  // Fault rise, ring fault entry, any phase change
  assign events[`MCS_IRQ_FAULT] = (faultPresent | nonrecoverable | majorRecoverable)
                                  & ~faultSeen;
  assign events[`MCS_IRQ_RING]  = (ringHwFault | ringSetupFault) & ~ringFaultPrev;
  assign events[`MCS_IRQ_PHASE] = (ringPhase != phasePrev);

  // One wait state: read data loaded when the request is taken so it stands
  // while waitrequest is low; writes land one edge later, where waitrequest is sampled low
  assign access  = avsRead & ~busy;
  assign wrEvent = avsWrite & busy;
  assign fire    = |(irqStat & irqMask);

  assign statusWord = {20'h0_0000, 1'b0, ringPhase, comm_phase_indicator, ringLed,
                       healthLed, dualAxisLed};

  // Bus handshake and registers
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy           <= 1'b0;
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h0000_0000;
      ctrl           <= `MCS_CTRL_RESET;
      irqStat        <= `MCS_IRQ_RESET;
      irqMask        <= `MCS_IRQ_RESET;
      irq            <= 1'b0;
    end
    else
    begin
      busy           <= (avsRead | avsWrite) & ~busy;
      avsWaitRequest <= ~((avsRead | avsWrite) & ~busy);
      irq            <= fire;
      // Set wins over a write-one clear in the same cycle
      if (wrEvent && avsAddress == `MCS_OFF_IRQSTAT && avsByteEnable[0])
        irqStat <= (irqStat & ~avsWriteData[2:0]) | events;
      else
        irqStat <= irqStat | events;
      if (wrEvent && avsAddress == `MCS_OFF_CTRL && avsByteEnable[0])
        ctrl[7:0] <= avsWriteData[7:0];
      if (wrEvent && avsAddress == `MCS_OFF_IRQMASK && avsByteEnable[0])
        irqMask <= avsWriteData[2:0];
      if (access)
      begin
        case (avsAddress)
          `MCS_OFF_CTRL:    avsReadData <= ctrl;
          `MCS_OFF_STATUS:  avsReadData <= statusWord;
          `MCS_OFF_IRQSTAT: avsReadData <= {29'h0000_0000, irqStat};
          `MCS_OFF_IRQMASK: avsReadData <= {29'h0000_0000, irqMask};
          default:          avsReadData <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// [testbench/mcs_leds_props.sv]
`timescale 1ns/1ps
`include "mcs_led_map.vh"
module mcs_leds_props (
  input wire        sys_clk,
  input wire        rst_n,
  input wire [3:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsReadData,
  input wire        avsWaitRequest,
  input wire        cardOperating,
  input wire        nonrecoverable,
  input wire        ringDataSeen,
  input wire        ringSetupFault,
  input wire        ringHwFault,
  input wire [2:0]  ringPhase,
  input wire [1:0]  healthLed,
  input wire [1:0]  ringLed,
  input wire [1:0]  comm_phase_indicator
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Exactly one wait state per access
  a_req_answered: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("request not answered in one cycle");
  a_wait_one_cycle: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
  a_unmapped_read_zero: assert property
    (!avsWaitRequest && $past(avsRead) && $past(avsAddress[1:0]) != 2'b00 |-> avsReadData == 0)
    else $error("unmapped read not zero");
  a_health_dark: assert property (!cardOperating |=> healthLed == `MCS_LED_OFF)
    else $error("health led lit while not operating");
  a_health_fatal: assert property
    (cardOperating && nonrecoverable |=> healthLed == `MCS_LED_RED)
    else $error("health led not solid red");
  a_ring_hw_red: assert property
    (ringHwFault && !ringSetupFault |=> ringLed == `MCS_LED_RED)
    else $error("ring led not red on hw fault");
  a_ring_no_data: assert property
    (!ringDataSeen && !ringHwFault && !ringSetupFault |=> ringLed == `MCS_LED_OFF)
    else $error("ring led lit without data");
  a_phase_autobaud: assert property
    (ringPhase == 3'h7 |=> comm_phase_indicator == `MCS_LED_ORANGE)
    else $error("phase led not orange");
  a_phase_active: assert property
    (ringPhase == 3'h4 |=> comm_phase_indicator == `MCS_LED_GREEN)
    else $error("phase led not green");
endmodule

// [testbench/mcs_led_viewer.sv]
`timescale 1ns/1ps
module mcs_led_viewer (
  input  wire       sys_clk,
  input  wire       eyeClr,
  input  wire [1:0] ledIn,
  output reg  [3:0] seenMask
);
  // Operator's eye: every colour shown since the last clear
  always @(posedge sys_clk)
    if (eyeClr)
      seenMask <= 4'h0;
    else
      seenMask <= seenMask | (4'h1 << ledIn);
endmodule

// [testbench/mcs_status_leds_tb_top.sv]
`timescale 1ns/1ps
`include "mcs_led_map.vh"
module mcs_status_leds_tb_top;
  logic        sys_clk = 0;
  logic        rst_n = 0;
  logic [3:0]  avsAddress = 0;
  logic        avsRead = 0;
  logic        avsWrite = 0;
  logic [31:0] avsWriteData = 0;
  logic [3:0]  avsByteEnable = 4'hF;
  wire  [31:0] avsReadData;
  wire         avsWaitRequest;
  wire         irq;
  logic        cardOperating = 0, selfTestDone = 0, selfTestPass = 0, dataExchange = 0;
  logic        faultPresent = 0, majorRecoverable = 0, nonrecoverable = 0;
  logic        nonvolatile_store_update = 0, ringDataSeen = 0, ringConfigured = 0;
  logic        ringIdentified = 0, ringSetupFault = 0, ringHwFault = 0;
  logic [2:0]  ringPhase = 3'h7;
  wire  [1:0]  dualAxisLed, healthLed, ringLed, comm_phase_indicator, eyeIn;
  logic [1:0]  ledSel = 0;
  logic        eyeClr = 1;
  wire  [3:0]  seenMask;
  logic [31:0] rd;
  int          n_fail = 0;
  int          check_count = 0;

  always #5 sys_clk = ~sys_clk;
  mcs_status_leds #(.BLINK_HALF_CYC(4)) mcs_status_leds_inst (.*);
  // Operator looks at one LED at a time
  assign eyeIn = ledSel[1] ? (ledSel[0] ? comm_phase_indicator : ringLed)
                           : (ledSel[0] ? healthLed : dualAxisLed);
  mcs_led_viewer mcs_led_viewer_inst (.sys_clk(sys_clk), .eyeClr(eyeClr), .ledIn(eyeIn),
                                      .seenMask(seenMask));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avsAddress <= a;
    avsWriteData <= d;
    avsRead <= !wr;
    avsWrite <= wr;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avsWaitRequest !== 1'b0 && k < 50);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    check(k < 50, 1, "bus answer");
    @(posedge sys_clk);
  endtask

  // Two blink periods, so any flashing shows both halves
  task automatic look(input logic [1:0] sel, input logic [3:0] exp, input string what);
    ledSel <= sel;
    eyeClr <= 1'b1;
    // Two clearing edges: a state change reaches the LED one edge later
    repeat (2) @(posedge sys_clk);
    eyeClr <= 1'b0;
    repeat (18) @(posedge sys_clk);
    check(seenMask, exp, what);
  endtask

  task automatic testDual;
    look(0, 4'h2, "dual pwrup");
    busXfer(1, `MCS_OFF_CTRL, 32'h0000_0001);
    look(0, 4'h4, "dual drv");
    busXfer(1, `MCS_OFF_CTRL, 32'h0000_0003);
    look(0, 4'h2, "dual prog");
    faultPresent <= 1'b1;
    look(0, 4'h4, "dual fault");
    faultPresent <= 1'b0;
  endtask

  task automatic testHealth;
    look(1, 4'h1, "hlth off");
    cardOperating <= 1'b1;
    look(1, 4'h4, "hlth test");
    selfTestDone <= 1'b1;
    selfTestPass <= 1'b1;
    look(1, 4'h3, "hlth idle");
    dataExchange <= 1'b1;
    look(1, 4'h2, "hlth run");
    nonvolatile_store_update <= 1'b1;
    look(1, 4'h5, "hlth store");
    nonvolatile_store_update <= 1'b0;
    majorRecoverable <= 1'b1;
    look(1, 4'h5, "hlth major");
    nonrecoverable <= 1'b1;
    look(1, 4'h4, "hlth fatal");
    nonrecoverable <= 1'b0;
    majorRecoverable <= 1'b0;
  endtask

  task automatic testRing;
    ringDataSeen <= 1'b1;
    ringConfigured <= 1'b1;
    ringPhase <= 3'h1;
    look(2, 4'h1, "ring early");
    ringPhase <= 3'h4;
    look(2, 4'h2, "ring up");
    ringConfigured <= 1'b0;
    ringIdentified <= 1'b1;
    ringPhase <= 3'h3;
    look(2, 4'h3, "ring ident");
    ringSetupFault <= 1'b1;
    look(2, 4'h5, "ring setup");
    ringSetupFault <= 1'b0;
    ringHwFault <= 1'b1;
    look(2, 4'h4, "ring hw");
    ringHwFault <= 1'b0;
    ringDataSeen <= 1'b0;
    look(2, 4'h1, "ring nodata");
  endtask

  task automatic testPhase;
    logic [2:0] ph [6] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [3:0] ex [6] = '{4'h8, 4'h1, 4'h5, 4'h6, 4'h3, 4'h2};
    int n;
    for (int i = 0; i < 6; i++)
    begin
      ringPhase <= ph[i];
      look(3, ex[i], "phase led");
    end
    ringPhase <= 3'h3;
    repeat (3) @(posedge sys_clk);
    n = 0;
    repeat (16)
    begin
      @(posedge sys_clk);
      n += (comm_phase_indicator === `MCS_LED_GREEN);
    end
    check(n, 8, "blink duty");
  endtask

  task automatic testRegs;
    busXfer(0, `MCS_OFF_IRQMASK, 0);
    check(rd, 0, "mask reset");
    busXfer(0, `MCS_OFF_CTRL, 0);
    check(rd, 3, "ctrl rw");
    busXfer(1, `MCS_OFF_IRQSTAT, 32'h0000_0007);
    busXfer(1, `MCS_OFF_IRQMASK, 32'h0000_0001);
    check(irq, 0, "irq idle");
    faultPresent <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(irq, 1, "irq set");
    faultPresent <= 1'b0;
    busXfer(1, `MCS_OFF_IRQSTAT, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    check(irq, 0, "irq clear");
    busXfer(1, `MCS_OFF_IRQMASK, 0);
    faultPresent <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(irq, 0, "irq masked");
    busXfer(0, `MCS_OFF_IRQSTAT, 0);
    check(rd, 1, "fault sticky");
    busXfer(0, 4'h6, 0);
    check(rd, 0, "unmapped");
    busXfer(0, `MCS_OFF_STATUS, 0);
    check(rd[10:8], 3, "status phase");
  endtask

  // Reset again mid-run, now with a failed self-test
  task automatic testReset;
    rst_n <= 1'b0;
    selfTestPass <= 1'b0;
    @(posedge sys_clk);
    check(healthLed, 0, "reset dark");
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    look(1, 4'h4, "hlth failed");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    testDual;
    testHealth;
    testRing;
    testPhase;
    testRegs;
    testReset;
    complete_run;
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end
endmodule

bind mcs_status_leds mcs_leds_props mcs_leds_props_inst (.*);
